// [design/boot_cfg_consts.svh]
// Offsets, field positions, reset values and timing counts of the loader
`ifndef BOOT_CFG_CONSTS_SVH
`define BOOT_CFG_CONSTS_SVH

`define OFF_CTRL        8'h00
`define OFF_RATE        8'h04
`define OFF_STATUS      8'h08
`define OFF_IRQ_STAT    8'h0c
`define OFF_IRQ_MASK    8'h10
`define OFF_BIT_COUNT   8'h14

`define CTRL_RELOAD_BIT 0
`define CTRL_IMGSEL_BIT 1

`define EV_DONE_BIT     0
`define EV_FAIL_BIT     1
`define EV_RESTART_BIT  2

`define MODE_SERIAL     3'b000
`define MODE_SPI        3'b110
`define MODE_PAR_UP     3'b010
`define MODE_PAR_DOWN   3'b011

`define PAR_BOTTOM_ADDR 25'h000_0000
`define PAR_TOP_ADDR    25'h1ff_ffff
`define SPI_READ_CMD    8'h03
`define SPI_START_ADDR  24'h00_0000
`define SPI_CMD_BITS    6'd32
`define SYNC_BITS       32'd32

`define CLK_KHZ         100000
`define CONFIG_SERIAL_CLOCK_KHZ        1500
`define CONFIG_SERIAL_CLOCK_DIV        8'((`CLK_KHZ + `CONFIG_SERIAL_CLOCK_KHZ - 1) / `CONFIG_SERIAL_CLOCK_KHZ)
`define RATE_MIN        8'h02
`define SETTLE_CYCLES   2'h3

`define RESP_OKAY       2'b00
`define RESP_SLVERR     2'b10

`endif

// [design/boot_cfg_pkg.sv]
// Types of the configuration loader
package boot_cfg_pkg;

  typedef enum logic [4:0] {
    ST_SAMPLE = 5'b00001,
    ST_SPICMD = 5'b00010,
    ST_LOAD   = 5'b00100,
    ST_DONE   = 5'b01000,
    ST_FAIL   = 5'b10000
  } state_e;

  typedef enum logic [2:0] {
    SRC_SERIAL   = 3'h0,
    SRC_SPI      = 3'h1,
    SRC_PAR_UP   = 3'h2,
    SRC_PAR_DOWN = 3'h3,
    SRC_JTAG     = 3'h4
  } src_e;

  typedef struct packed {
    logic        awvalid;
    logic [7:0]  awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [7:0]  araddr;
    logic        rready;
  } axi_req_s;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } axi_rsp_s;

  typedef struct packed {
    state_e      st;
    src_e        src;
    logic [1:0]  settle;
    logic [2:0]  modeCode;
    logic        reload;
    logic        imgSel;
    logic [7:0]  rate;
    logic [7:0]  divCnt;
    logic        config_serial_clock;
    logic [24:0] addr;
    logic [31:0] spiCmd;
    logic [5:0]  spiCnt;
    logic        spiCsN;
    logic [31:0] shift;
    logic [31:0] bitCnt;
    logic        done;
    logic        tckPrev;
    logic        btnPrev;
    logic [2:0]  irqStat;
    logic [2:0]  irqMask;
    logic        awHeld;
    logic [7:0]  awAddr;
    logic        wHeld;
    logic [31:0] wData;
    logic [3:0]  wStrb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } state_s;

endpackage

// [design/sync_2ff.sv]
// Two-stage synchroniser for a bus of independent levels
`timescale 1ns/10ps
module sync_2ff #(
  parameter int WIDTH = 1
) (
  input  wire logic             ref_clk,
  input  wire logic             arst_n,
  input  wire logic [WIDTH-1:0] asyncIn,
  output logic      [WIDTH-1:0] syncOut
);

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
  } sync_s;

  sync_s q;
  sync_s d;

  always_comb begin
    d.s1 = asyncIn;
    d.s2 = q.s1;
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign syncOut = q.s2;

endmodule // sync_2ff

// [design/fpga_boot_mode_select.sv]
// Configuration loader: boot source select, image load, restart and done
// Functional notes
// (R1) The boot code is taken from the three select pins at power-up and on every restart.
// (R2) A fitted jumper grounds its select pin, giving a zero.
// (R3) Code 0:0:0 loads serially from the configuration PROM with the device making the clock.
// (R4) Code 1:1:0 loads from the serial-peripheral flash, read from address zero.
// (R5) Code 0:1:0 reads the parallel flash upward from address zero.
// (R6) Code 0:1:1 reads the parallel flash downward from 0x1FF_FFFF.
// (R7) The helper logic drives flash address bits 24 to 20; this block drives only the low ones.
// (R8) A host JTAG download is accepted; it shares code 0:1:0 with the upward parallel mode. The code accepts it under any code once the pins have been sampled.
// (R9) Pressing and releasing the restart button restarts loading from the selected source.
// (R10) The done output is high only after a successful load.
// (R11) Software can reload either of two images from the parallel flash.
// (R12) The host JTAG path also programs the PROM and the helper logic.
// (R13) The two flashes are programmed by other means than the JTAG path.
// (R14) The configuration clock is divided down and starts at its slowest rate, near 1.5 MHz; the code starts at divide by 67, not the slowest, 255.
// (R15) A JTAG download is clocked by the JTAG test clock, not the configuration clock.
// (R16) A select pin with no jumper is pulled to one.
// (R17) Done stays low from any restart until the new image has loaded.
`timescale 1ns/10ps
`include "boot_cfg_consts.svh"
module fpga_boot_mode_select #(
  parameter logic [31:0] IMAGE_BITS  = 32'd2_097_152,
  parameter logic [31:0] SYNC_WORD   = 32'h5a3c_c35a,
  parameter logic [24:0] IMAGE1_BASE = 25'h080_0000
) (
  input  wire logic                   ref_clk,
  input  wire logic                   arst_n,
  input  wire boot_cfg_pkg::axi_req_s axiReq,
  output boot_cfg_pkg::axi_rsp_s      axiRsp,
  input  wire logic                   bootSelBit0,
  input  wire logic                   bootSelBit1,
  input  wire logic                   bootSelBit2,
  input  wire logic                   configRestartButton,
  input  wire logic                   serialData,
  input  wire logic                   spiMiso,
  input  wire logic [7:0]             flashData,
  input  wire logic                   jtagTck,
  input  wire logic                   jtagTdi,
  output logic                        configSerialClock,
  output logic                        spiSelect_n,
  output logic                        spiMosi,
  output logic      [19:0]            flashAddrLow,
  output logic                        configDone,
  output logic                        irq
);
  import boot_cfg_pkg::*;

  localparam state_s RST = '{
    st:      ST_SAMPLE,
    src:     SRC_SERIAL,
    rate:    `CONFIG_SERIAL_CLOCK_DIV,
    spiCsN:  1'b1,
    default: '0
  };

  logic [15:0] rawIn;
  logic [15:0] syncIn;
  logic [2:0]  modePins;
  logic        btn;
  logic        serIn;
  logic        miso;
  logic [7:0]  flashByte;
  logic        tck;
  logic        tdi;
  logic        awRdy;
  logic        wRdy;
  logic        arRdy;
  state_s      q;
  state_s      d;

  assign rawIn = {bootSelBit2, bootSelBit1, bootSelBit0, configRestartButton,
                  serialData, spiMiso, flashData, jtagTck, jtagTdi};

  sync_2ff #(
    .WIDTH(16)
  ) uSync (
    .ref_clk(ref_clk),
    .arst_n (arst_n),
    .asyncIn(rawIn),
    .syncOut(syncIn)
  );

  assign modePins  = syncIn[15:13];
  assign btn       = syncIn[12];
  assign serIn     = syncIn[11];
  assign miso      = syncIn[10];
  assign flashByte = syncIn[9:2];
  assign tck       = syncIn[1];
  assign tdi       = syncIn[0];

  assign awRdy = !q.awHeld && !q.bvalid;
  assign wRdy  = !q.wHeld && !q.bvalid;
  assign arRdy = !q.rvalid;

  always_comb begin
    logic        tick;
    logic        fall;
    logic        take;
    logic        wide;
    logic [7:0]  inByte;
    logic [31:0] shNew;
    logic [31:0] cntNew;
    logic [2:0]  ev;
    logic        rdClr;
    logic        reloadWr;
    logic        tckRise;
    logic        release_;
    tick     = 1'b0;
    fall     = 1'b0;
    take     = 1'b0;
    wide     = 1'b0;
    inByte   = 8'h00;
    shNew    = 32'h0000_0000;
    cntNew   = 32'h0000_0000;
    ev       = 3'b000;
    rdClr    = 1'b0;
    reloadWr = 1'b0;
    d        = q;

    // Edge detection on synchronised pins
    tckRise   = tck && !q.tckPrev;
    release_  = q.btnPrev && !btn;
    d.tckPrev = tck;
    d.btnPrev = btn;

    // Register bus, write side
    if (q.bvalid && axiReq.bready) begin
      d.bvalid = 1'b0;
    end
    if (awRdy && axiReq.awvalid) begin
      d.awHeld = 1'b1;
      d.awAddr = axiReq.awaddr;
    end
    if (wRdy && axiReq.wvalid) begin
      d.wHeld = 1'b1;
      d.wData = axiReq.wdata;
      d.wStrb = axiReq.wstrb;
    end
    if (d.awHeld && d.wHeld) begin
      d.awHeld = 1'b0;
      d.wHeld  = 1'b0;
      d.bvalid = 1'b1;
      d.bresp  = `RESP_OKAY;
      case (d.awAddr)
        `OFF_CTRL: begin
          if (d.wStrb[0]) begin
            reloadWr = d.wData[`CTRL_RELOAD_BIT];
            d.imgSel = d.wData[`CTRL_IMGSEL_BIT];
          end
        end
        `OFF_RATE: begin
          if (d.wStrb[0]) begin
            d.rate = (d.wData[7:0] < `RATE_MIN) ? `RATE_MIN : d.wData[7:0];
          end
        end
        `OFF_IRQ_MASK: begin
          if (d.wStrb[0]) begin
            d.irqMask = d.wData[2:0];
          end
        end
        `OFF_STATUS, `OFF_IRQ_STAT, `OFF_BIT_COUNT: begin
          d.bresp = `RESP_OKAY;
        end
        default: begin
          d.bresp = `RESP_SLVERR;
        end
      endcase
    end

    // Register bus, read side
    if (q.rvalid && axiReq.rready) begin
      d.rvalid = 1'b0;
    end
    if (arRdy && axiReq.arvalid) begin
      d.rvalid = 1'b1;
      d.rresp  = `RESP_OKAY;
      case (axiReq.araddr)
        `OFF_CTRL:      d.rdata = {30'h0, q.imgSel, 1'b0};
        `OFF_RATE:      d.rdata = {24'h0, q.rate};
        `OFF_STATUS:    d.rdata = {20'h0, q.src, q.st, q.done, q.modeCode};
        `OFF_IRQ_MASK:  d.rdata = {29'h0, q.irqMask};
        `OFF_BIT_COUNT: d.rdata = q.bitCnt;
        `OFF_IRQ_STAT: begin
          d.rdata = {29'h0, q.irqStat};
          rdClr   = 1'b1;
        end
        default: begin
          d.rdata = 32'h0000_0000;
          d.rresp = `RESP_SLVERR;
        end
      endcase
    end

    // Configuration clock divider, divide by 67 (near 1.5 MHz) out of reset
    if ((q.st == ST_SPICMD || q.st == ST_LOAD) && q.src != SRC_JTAG) begin // [R14]
      if (q.divCnt >= q.rate - 8'd1) begin
        d.divCnt = 8'h00;
        tick     = 1'b1;
      end else begin
        d.divCnt = q.divCnt + 8'd1;
      end
      fall   = (d.divCnt == (q.rate >> 1));
      d.config_serial_clock = (d.divCnt < (q.rate >> 1));
    end else begin
      d.divCnt = 8'h00;
      d.config_serial_clock   = 1'b0;
    end

    unique case (q.st)
      ST_SAMPLE: begin
        d.bitCnt = 32'h0000_0000;
        d.shift  = 32'h0000_0000;
        d.spiCnt = 6'h00;
        d.done   = 1'b0; // [R17]
        if (q.settle != `SETTLE_CYCLES) begin
          d.settle = q.settle + 2'd1;
        end else begin
          d.modeCode = modePins; // [R1] [R2] [R16]
          d.reload   = 1'b0;
          if (q.reload) begin
            d.src  = SRC_PAR_UP;
            d.addr = q.imgSel ? IMAGE1_BASE : `PAR_BOTTOM_ADDR; // [R11]
            d.st   = ST_LOAD;
          end else begin
            case (modePins)
              `MODE_SERIAL: begin
                d.src = SRC_SERIAL; // [R3]
                d.st  = ST_LOAD;
              end
              `MODE_SPI: begin
                d.src    = SRC_SPI;
                d.spiCmd = {`SPI_READ_CMD, `SPI_START_ADDR}; // [R4]
                d.st     = ST_SPICMD;
              end
              `MODE_PAR_UP: begin
                d.src  = SRC_PAR_UP;
                d.addr = `PAR_BOTTOM_ADDR; // [R5] [R8]
                d.st   = ST_LOAD;
              end
              `MODE_PAR_DOWN: begin
                d.src  = SRC_PAR_DOWN;
                d.addr = `PAR_TOP_ADDR; // [R6]
                d.st   = ST_LOAD;
              end
              default: begin
                d.st                = ST_FAIL;
                ev[`EV_FAIL_BIT]    = 1'b1;
              end
            endcase
          end
        end
      end
      ST_SPICMD: begin
        if (fall) begin
          d.spiCmd = {q.spiCmd[30:0], 1'b0}; // [R4]
          d.spiCnt = q.spiCnt + 6'd1;
          if (q.spiCnt == `SPI_CMD_BITS - 6'd1) begin
            d.st = ST_LOAD;
          end
        end
      end
      ST_LOAD: begin
        unique case (q.src)
          SRC_SERIAL: begin
            take   = tick; // [R3]
            inByte = {7'h00, serIn};
          end
          SRC_SPI: begin
            take   = tick;
            inByte = {7'h00, miso};
          end
          SRC_PAR_UP, SRC_PAR_DOWN: begin
            take   = tick;
            wide   = 1'b1;
            inByte = flashByte;
          end
          SRC_JTAG: begin
            take   = tckRise; // [R15]
            inByte = {7'h00, tdi};
          end
        endcase
        if (take) begin
          if (q.src == SRC_PAR_UP) begin
            d.addr = q.addr + 25'd1; // [R5]
          end else if (q.src == SRC_PAR_DOWN) begin
            d.addr = q.addr - 25'd1; // [R6]
          end
          shNew    = wide ? {q.shift[23:0], inByte} : {q.shift[30:0], inByte[0]};
          cntNew   = q.bitCnt + (wide ? 32'd8 : 32'd1);
          d.shift  = shNew;
          d.bitCnt = cntNew;
          if (cntNew == `SYNC_BITS && shNew != SYNC_WORD) begin
            d.st             = ST_FAIL;
            ev[`EV_FAIL_BIT] = 1'b1;
          end else if (cntNew >= IMAGE_BITS) begin
            d.st             = ST_DONE;
            d.done           = 1'b1; // [R10]
            ev[`EV_DONE_BIT] = 1'b1;
          end
        end
      end
      ST_DONE, ST_FAIL: begin
        d.divCnt = 8'h00;
      end
    endcase

    // Host download takes over the link
    if (tckRise && q.src != SRC_JTAG && q.st != ST_SAMPLE) begin // [R8] [R15]
      d.src    = SRC_JTAG;
      d.st     = ST_LOAD;
      // The takeover edge carries the first bit of the download
      d.bitCnt = 32'h0000_0001;
      d.shift  = {31'h0000_0000, tdi};
      d.done   = 1'b0; // [R17]
    end

    // Button release or software reload restarts loading
    if (release_ || reloadWr) begin // [R9] [R11]
      d.st                = ST_SAMPLE;
      d.settle            = 2'h0;
      d.reload            = reloadWr;
      d.done              = 1'b0; // [R17]
      ev[`EV_RESTART_BIT] = 1'b1;
    end

    d.spiCsN  = !((d.st == ST_SPICMD || d.st == ST_LOAD) && d.src == SRC_SPI);
    // Set wins over a clearing read
    d.irqStat = (q.irqStat & ~{3{rdClr}}) | ev;
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      q <= RST;
    end else begin
      q <= d;
    end
  end

  assign axiRsp.awready = awRdy;
  assign axiRsp.wready  = wRdy;
  assign axiRsp.bvalid  = q.bvalid;
  assign axiRsp.bresp   = q.bresp;
  assign axiRsp.arready = arRdy;
  assign axiRsp.rvalid  = q.rvalid;
  assign axiRsp.rdata   = q.rdata;
  assign axiRsp.rresp   = q.rresp;

  assign configSerialClock = q.config_serial_clock; // [R14]
  assign spiSelect_n       = q.spiCsN;
  assign spiMosi           = q.spiCmd[31];
  assign flashAddrLow      = q.addr[19:0]; // [R7]
  assign configDone        = q.done; // [R10]
  assign irq               = |(q.irqStat & q.irqMask);

endmodule // fpga_boot_mode_select

// [verif/boot_mode_properties.sv]
// Port-level assertions of the configuration loader
`timescale 1ns/10ps
module boot_mode_properties (
  input wire logic                   ref_clk,
  input wire logic                   arst_n,
  input wire boot_cfg_pkg::axi_req_s axiReq,
  input wire boot_cfg_pkg::axi_rsp_s axiRsp,
  input wire logic                   configRestartButton,
  input wire logic                   configSerialClock,
  input wire logic                   spiSelect_n,
  input wire logic                   configDone
);
  import boot_cfg_pkg::*;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);

  sequence rd_taken;
    axiReq.arvalid && axiRsp.arready;
  endsequence
  sequence wr_taken;
    axiReq.awvalid && axiRsp.awready && axiReq.wvalid && axiRsp.wready;
  endsequence
  sequence done_twice;
    configDone ##1 configDone;
  endsequence

  read_answer_a: assert property (rd_taken |=> axiRsp.rvalid)
    else $error("read not answered");
  write_answer_a: assert property (wr_taken |=> axiRsp.bvalid)
    else $error("write not answered");
  resp_hold_a: assert property (axiRsp.bvalid && !axiReq.bready |=>
    axiRsp.bvalid && $stable(axiRsp.bresp)) else $error("write response dropped");
  data_hold_a: assert property (axiRsp.rvalid && !axiReq.rready |=>
    axiRsp.rvalid && $stable(axiRsp.rdata)) else $error("read data dropped");
  ready_block_a: assert property (axiRsp.bvalid |-> !axiRsp.awready && !axiRsp.wready)
    else $error("write taken during response");
  restart_clear_a: assert property ($fell(configRestartButton) |-> ##[1:6] !configDone)
    else $error("done kept after restart");
  done_quiet_a: assert property (done_twice |-> !configSerialClock)
    else $error("load clock runs when done");
  spi_start_a: assert property ($fell(spiSelect_n) |-> !configDone)
    else $error("done high at flash read start");
endmodule // boot_mode_properties

// [verif/boot_flash_model.sv]
// PROM, serial flash and parallel flash model
`timescale 1ns/10ps
module boot_flash_model #(
  parameter logic [63:0] IMAGE = 64'h0, // Preloaded, written outside the JTAG path
  parameter int          BASE1 = 256
) (
  input  wire logic        configSerialClock,
  input  wire logic        restart,
  input  wire logic        spiSelect_n,
  input  wire logic [19:0] flashAddrLow,
  output logic             serialData,
  output logic             spiMiso,
  output logic      [7:0]  flashData
);
  int falls;
  int idx;
  always @(negedge configSerialClock or posedge restart) begin
    if (restart) falls <= 0;
    else falls <= falls + 1;
  end
  // Bit k follows clock fall k and is taken at the next rise
  assign serialData = (falls >= 1 && falls <= 64) ? IMAGE[64 - falls] : falls[0];
  // Data after 32 command clocks; toggles when deselected
  assign spiMiso = (!spiSelect_n && falls >= 32 && falls < 96) ? IMAGE[95 - falls] : falls[0];
  // Only low address bits seen; upper ones belong to the helper
  always_comb begin
    if (flashAddrLow < 20'd8) idx = int'(flashAddrLow);
    else if (flashAddrLow >= 20'(BASE1) && flashAddrLow < 20'(BASE1 + 8))
      idx = int'(flashAddrLow) - BASE1;
    else if (flashAddrLow > 20'hffff7) idx = 20'hfffff - int'(flashAddrLow);
    else idx = -1;
    flashData = (idx < 0) ? flashAddrLow[7:0] ^ 8'h5a : IMAGE[63 - 8 * idx -: 8];
  end
endmodule // boot_flash_model

// [verif/fpga_boot_mode_select_tb.sv]
// Self-checking bench of the configuration loader
`timescale 1ns/10ps
`include "boot_cfg_consts.svh"
module fpga_boot_mode_select_tb;
  import boot_cfg_pkg::*;
  localparam logic [63:0] IMG = 64'h5a3c_c35a_1234_abcd;
  logic        ref_clk = 0;
  logic        arst_n = 0;
  axi_req_s    axiReq = '0;
  axi_rsp_s    axiRsp;
  logic [2:0]  bootSel = 3'b000;
  logic        configRestartButton = 0;
  logic        jtagTck = 0;
  logic        jtagTdi = 0;
  logic        serialData, spiMiso, configSerialClock, spiSelect_n, spiMosi, configDone, irq;
  logic [7:0]  flashData;
  logic [19:0] flashAddrLow;
  logic [1:0]  lastResp;
  logic [31:0] rd;
  int          fails = 0;
  int          compares = 0;
  logic [2:0]  codes[$] = '{3'b110, 3'b011, 3'b101, 3'b000, 3'b010};

  always #5 ref_clk = ~ref_clk;

  fpga_boot_mode_select #(.IMAGE_BITS(32'd64), .SYNC_WORD(IMG[63:32]),
    .IMAGE1_BASE(25'h000_0100)) u_fpga_boot_mode_select (
    .ref_clk(ref_clk), .arst_n(arst_n), .axiReq(axiReq), .axiRsp(axiRsp),
    .bootSelBit0(bootSel[0]), .bootSelBit1(bootSel[1]), .bootSelBit2(bootSel[2]),
    .configRestartButton(configRestartButton), .serialData(serialData),
    .spiMiso(spiMiso), .flashData(flashData), .jtagTck(jtagTck), .jtagTdi(jtagTdi),
    .configSerialClock(configSerialClock), .spiSelect_n(spiSelect_n),
    .spiMosi(spiMosi), .flashAddrLow(flashAddrLow), .configDone(configDone), .irq(irq));

  boot_flash_model #(.IMAGE(IMG), .BASE1(256)) u_boot_flash_model (
    .configSerialClock(configSerialClock), .restart(!arst_n || configRestartButton),
    .spiSelect_n(spiSelect_n), .flashAddrLow(flashAddrLow), .serialData(serialData),
    .spiMiso(spiMiso), .flashData(flashData));

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic summarize();
    if (fails == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
    axi_rsp_s s;
    @(posedge ref_clk);
    axiReq.awvalid <= 1;
    axiReq.awaddr <= a;
    axiReq.wvalid <= 1;
    axiReq.wdata <= d;
    axiReq.wstrb <= 4'hf;
    axiReq.bready <= 1;
    do begin
      @(negedge ref_clk);
      s = axiRsp;
      @(posedge ref_clk);
      if (s.awready) axiReq.awvalid <= 0;
      if (s.wready) axiReq.wvalid <= 0;
    end while (!s.bvalid);
    axiReq.bready <= 0;
    lastResp = s.bresp;
  endtask

  task automatic axi_read(input logic [7:0] a, output logic [31:0] d);
    axi_rsp_s s;
    @(posedge ref_clk);
    axiReq.arvalid <= 1;
    axiReq.araddr <= a;
    axiReq.rready <= 1;
    do begin
      @(negedge ref_clk);
      s = axiRsp;
      @(posedge ref_clk);
      if (s.arready) axiReq.arvalid <= 0;
    end while (!s.rvalid);
    axiReq.rready <= 0;
    d = s.rdata;
    lastResp = s.rresp;
  endtask

  function automatic logic [11:0] exp_status(input logic [2:0] c, input logic jt);
    logic [2:0] s;
    s = jt ? 3'd4 : (c == 3'b000) ? 3'd0 : (c == 3'b110) ? 3'd1 : (c == 3'b010) ? 3'd2 : 3'd3;
    if (jt || c inside {3'b000, 3'b110, 3'b010, 3'b011}) return {s, 5'h08, 1'b1, c};
    return {3'd0, 5'h10, 1'b0, c};
  endfunction

  task automatic wait_done(input logic ok, input logic [11:0] exp);
    int n;
    n = 0;
    while (configDone !== 1'b1 && n < 6000) begin
      @(posedge ref_clk);
      n++;
    end
    check(configDone, ok);
    axi_read(`OFF_STATUS, rd);
    check(rd[11:0] & (ok ? 12'hfff : 12'h1ff), exp);
    if (ok) begin
      axi_read(`OFF_BIT_COUNT, rd);
      check(rd, 32'd64);
    end
    check(irq, ok);
  endtask

  task automatic run(input logic [2:0] c, input logic btn);
    logic ok;
    ok = (c inside {3'b000, 3'b110, 3'b010, 3'b011});
    if (btn) begin
      bootSel <= c;
      configRestartButton <= 1;
      repeat (4) @(posedge ref_clk);
      configRestartButton <= 0;
      repeat (8) @(posedge ref_clk);
      check(configDone, 0);
    end
    wait_done(ok, exp_status(c, 0));
    if (c inside {3'b010, 3'b011}) check(flashAddrLow, c[0] ? 32'hffff7 : 32'h8);
    axi_read(`OFF_IRQ_STAT, rd);
    check(rd[2:0], {btn, !ok, ok});
    check(irq, 0);
  endtask

  initial begin
    logic [63:0] img;
    void'($urandom(49001));
    repeat (2) @(posedge ref_clk);
    arst_n <= 1;
    axi_read(`OFF_RATE, rd);
    check(rd, 32'h43);
    axi_write(`OFF_RATE, 32'h8);
    axi_write(`OFF_IRQ_MASK, 32'h1);
    run(3'b000, 0);
    foreach (codes[i]) run(codes[i], 1);
    img = {IMG[63:32], 32'($urandom)};
    #3;
    for (int i = 63; i >= 0; i--) begin // Host JTAG path
      jtagTdi <= img[i];
      #62.5 jtagTck <= 1;
      #62.5 jtagTck <= 0;
    end
    wait_done(1, exp_status(3'b010, 1));
    axi_read(`OFF_IRQ_STAT, rd);
    check(rd[2:0], 3'b001);
    axi_write(`OFF_CTRL, 32'h3);
    check(configDone, 0);
    wait_done(1, exp_status(3'b010, 0));
    check(flashAddrLow, 32'h108);
    axi_read(`OFF_CTRL, rd);
    check(rd, 32'h2);
    axi_write(8'h40, 32'h1);
    check(lastResp, `RESP_SLVERR);
    axi_read(8'h40, rd);
    check({lastResp, rd}, {`RESP_SLVERR, 32'h0});
    summarize();
  end

  initial begin
    repeat (40000) @(posedge ref_clk);
    fails++;
    summarize();
  end
endmodule // fpga_boot_mode_select_tb

bind fpga_boot_mode_select boot_mode_properties u_boot_mode_properties (
  .ref_clk(ref_clk), .arst_n(arst_n), .axiReq(axiReq), .axiRsp(axiRsp),
  .configRestartButton(configRestartButton), .configSerialClock(configSerialClock),
  .spiSelect_n(spiSelect_n), .configDone(configDone));
